// ==== logic/pwmcps_map.vh ====
`ifndef PWMCPS_MAP_VH
`define PWMCPS_MAP_VH

// Word byte addresses on the Wishbone slave
`define PWMCPS_ADDR_PIN_CFG      16'h1FC0
`define PWMCPS_ADDR_PERIOD       16'h1FB4
`define PWMCPS_ADDR_DUTY0        16'h1FB0
`define PWMCPS_ADDR_DUTY1        16'h1FB8
`define PWMCPS_ADDR_COUNT        16'h1FBC

// Field positions of the output configuration register
`define PWMCPS_BIT_SEL1          12
`define PWMCPS_BIT_SEL0          11
`define PWMCPS_BIT_LVL1          7
`define PWMCPS_BIT_LVL0          6

// Reset values
`define PWMCPS_RST_PIN_CFG       16'h0000
`define PWMCPS_RST_PERIOD        8'h00
`define PWMCPS_RST_DUTY          8'h00
`define PWMCPS_RST_COUNT         8'h00

// State time: core clocks per counter state step
`define PWMCPS_STATE_CLKS        2

`endif

// ==== logic/pwmcps_core.v ====
`timescale 1ns/1ps
`include "pwmcps_map.vh"

// Period down-counter and two duty comparators
module pwmcps_core #(
	parameter WIDTH = 8
) (
	input  wire             clk_i,
	input  wire             rst_i,
	input  wire [WIDTH-1:0] period_i,
	input  wire [WIDTH-1:0] duty0_i,
	input  wire [WIDTH-1:0] duty1_i,
	output reg  [WIDTH-1:0] count_o,
	output reg              out0_o,
	output reg              out1_o
);

	reg  [WIDTH-1:0] cur0_q;
	reg  [WIDTH-1:0] cur1_q;
	reg  [WIDTH-1:0] pre_q;
	reg  [WIDTH-1:0] pos_q;
	reg  [1:0]       st_q;
	wire             step;
	wire             pstart;

	// Two-bit divider: the state time may not exceed four clocks
	localparam [1:0] ST_LAST = `PWMCPS_STATE_CLKS - 1;

	// State-time enable divides the core clock
	assign step   = (st_q == ST_LAST);
	assign pstart = step && (pre_q == 8'h00) && (count_o == 8'h00);

	always @(posedge clk_i) begin
		if (rst_i) begin
			st_q    <= 2'b00;
			pre_q   <= `PWMCPS_RST_PERIOD;
			count_o <= `PWMCPS_RST_COUNT;
			pos_q   <= 8'h00;
			cur0_q  <= `PWMCPS_RST_DUTY;
			cur1_q  <= `PWMCPS_RST_DUTY;
			out0_o  <= 1'b0;
			out1_o  <= 1'b0;
		end else begin
			st_q <= step ? 2'b00 : st_q + 2'b01;
			if (step) begin
				// Counter advances once every period+1 state times
				if (pre_q == 8'h00) begin
					pre_q <= period_i;
					if (count_o == 8'h00) begin
						count_o <= 8'hFF;
						pos_q   <= 8'h00;
					end else begin
						count_o <= count_o - 8'h01;
						pos_q   <= pos_q + 8'h01;
					end
				end else begin
					pre_q <= pre_q - 8'h01;
				end
			end
			// Buffered duty takes effect only at the period start
			if (pstart) begin
				cur0_q <= duty0_i;
				cur1_q <= duty1_i;
			end
			// Zero duty keeps the output low; high for duty counts
			out0_o <= (pos_q < cur0_q);
			out1_o <= (pos_q < cur1_q);
		end
	end

endmodule

// ==== logic/pwmcps_top.v ====
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`include "pwmcps_map.vh"

// Notes on behaviour
// - Count readback register returns the live down-counter, read-only.
// - Config bit 12 set routes second output to its pin, else port.
// - Config bit 11 set routes first output to its pin, else port.
// - Config bit 7 is the second pin's level in port mode.
// - Config bit 6 is the first pin's level in port mode.
// - Remaining config fields belong to the waveform generator, stored.
// - New duty values wait in a buffer until the next period.
// - Zero duty gives constant low; else high for duty of 256 counter steps.
// - Period register sets state times per counter step.
module pwmcps_top (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [15:0] wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output reg         wb_err_o,
	output reg         port_six_bit_six_o,
	output reg         port_six_bit_seven_o,
	output reg  [5:0]  wave_fields_o,
	output reg  [7:0]  wave_ctrl_o
);

	reg  [15:0] pin_output_config_q;
	reg  [7:0]  period_q;
	reg  [7:0]  duty0_q;
	reg  [7:0]  duty1_q;
	wire [7:0]  count;
	wire        first_modulator_output;
	wire        second_modulator_output;
	wire        req;
	wire        hit;
	wire        wr;
	wire [7:0]  lo_byte;

	function is_mapped;
		input [15:0] a;
		begin
			is_mapped = (a == `PWMCPS_ADDR_PIN_CFG) ||
			            (a == `PWMCPS_ADDR_PERIOD) ||
			            (a == `PWMCPS_ADDR_DUTY0) ||
			            (a == `PWMCPS_ADDR_DUTY1) ||
			            (a == `PWMCPS_ADDR_COUNT);
		end
	endfunction

	// Single-cycle answer; ack drops the cycle after it was given
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign hit = is_mapped(wb_adr_i);
	assign wr  = req && hit && wb_we_i;
	assign lo_byte = wb_dat_i[7:0];

	pwmcps_core #(
		.WIDTH(8)
	) u_core (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.period_i(period_q),
		.duty0_i (duty0_q),
		.duty1_i (duty1_q),
		.count_o (count),
		.out0_o  (first_modulator_output),
		.out1_o  (second_modulator_output)
	);

	always @(posedge clk_i) begin
		if (rst_i) begin
			pin_output_config_q <= `PWMCPS_RST_PIN_CFG;
			period_q            <= `PWMCPS_RST_PERIOD;
			duty0_q             <= `PWMCPS_RST_DUTY;
			duty1_q             <= `PWMCPS_RST_DUTY;
			wb_ack_o            <= 1'b0;
			wb_err_o            <= 1'b0;
			wb_dat_o            <= 32'h00000000;
		end else begin
			wb_ack_o <= req && hit;
			wb_err_o <= req && !hit;
			wb_dat_o <= 32'h00000000;
			if (wr) begin
				case (wb_adr_i)
				`PWMCPS_ADDR_PIN_CFG: begin
					// All fields kept, wave fields too
					if (wb_sel_i[0])
						pin_output_config_q[7:0] <= lo_byte;
					if (wb_sel_i[1])
						pin_output_config_q[15:8] <= wb_dat_i[15:8];
				end
				`PWMCPS_ADDR_PERIOD: begin
					if (wb_sel_i[0])
						period_q <= lo_byte;
				end
				`PWMCPS_ADDR_DUTY0: begin
					if (wb_sel_i[0])
						duty0_q <= lo_byte;
				end
				`PWMCPS_ADDR_DUTY1: begin
					if (wb_sel_i[0])
						duty1_q <= lo_byte;
				end
				default: begin
					// Count readback writes are acked and dropped
				end
				endcase
			end
			if (req && hit && !wb_we_i) begin
				case (wb_adr_i)
				`PWMCPS_ADDR_PIN_CFG:
					wb_dat_o <= {16'h0000, pin_output_config_q};
				`PWMCPS_ADDR_PERIOD:
					wb_dat_o <= {24'h000000, period_q};
				`PWMCPS_ADDR_DUTY0:
					wb_dat_o <= {24'h000000, duty0_q};
				`PWMCPS_ADDR_DUTY1:
					wb_dat_o <= {24'h000000, duty1_q};
				`PWMCPS_ADDR_COUNT:
					wb_dat_o <= {24'h000000, count};
				default:
					wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	// Pin mux is registered so the pins change one cycle after the write
	always @(posedge clk_i) begin
		if (rst_i) begin
			port_six_bit_six_o   <= 1'b0;
			port_six_bit_seven_o <= 1'b0;
			wave_fields_o        <= 6'h00;
			wave_ctrl_o          <= 8'h00;
		end else begin
			port_six_bit_six_o <=
				pin_output_config_q[`PWMCPS_BIT_SEL0] ?
				first_modulator_output :
				pin_output_config_q[`PWMCPS_BIT_LVL0];
			port_six_bit_seven_o <=
				pin_output_config_q[`PWMCPS_BIT_SEL1] ?
				second_modulator_output :
				pin_output_config_q[`PWMCPS_BIT_LVL1];
			// Waveform-generator fields handed on untouched
			wave_fields_o <= pin_output_config_q[5:0];
			wave_ctrl_o   <= {2'b00, pin_output_config_q[15:13],
			                  pin_output_config_q[10:8]};
		end
	end

endmodule

// ==== tb/pwmcps_asserts.sv ====
`timescale 1ns/1ps
module pwmcps_asserts (
	input wire        clk_i,
	input wire        rst_i,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [15:0] wb_adr_i,
	input wire [3:0]  wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire        wb_err_o,
	input wire        port_six_bit_six_o,
	input wire        port_six_bit_seven_o,
	input wire [7:0]  wave_ctrl_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire rq = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	wire cf = wb_adr_i == 16'h1FC0;
	wire cn = wb_adr_i == 16'h1FBC;
	sequence cfgw;
		rq & wb_we_i & cf & (&wb_sel_i[1:0]) ##1 wb_ack_o;
	endsequence
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_ack_cause: assert property (wb_ack_o |-> $past(rq))
		else $error("ack without request");
	a_cfg_ack: assert property (rq & cf |=> wb_ack_o & !wb_err_o)
		else $error("config access refused");
	a_pin_six: assert property (cfgw |-> ##1 ($past(wb_dat_i[11], 2) ||
		port_six_bit_six_o == $past(wb_dat_i[6], 2))) else $error("pin six");
	a_pin_seven: assert property (cfgw |-> ##1 ($past(wb_dat_i[12], 2) ||
		port_six_bit_seven_o == $past(wb_dat_i[7], 2))) else $error("pin seven");
	a_cnt_width: assert property (rq & ~wb_we_i & cn |=>
		wb_dat_o[31:8] == 24'h000000) else $error("count too wide");
	a_cnt_write: assert property (rq & wb_we_i & cn |=> wb_ack_o)
		else $error("count write refused");
	a_wave_top: assert property (wave_ctrl_o[7:6] == 2'b00)
		else $error("wave control top bits");
	a_wave_map: assert property (cfgw |-> ##1
		wave_ctrl_o[5:0] == {$past(wb_dat_i[15:13], 2),
		$past(wb_dat_i[10:8], 2)}) else $error("wave fields");
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`include "pwmcps_map.vh"
module tb_top;
	logic        clk_i = 0;
	logic        rst_i = 1;
	logic [50:0] req = 0;
	logic [31:0] r;
	logic        e;
	logic [17:0] v;
	wire  [31:0] dr;
	wire         ack, err, p6, p7;
	wire  [5:0]  wf;
	wire  [7:0]  wc;
	int          num_errors = 0, n_compared = 0, i, h6, h7;
	int          t = 0, tk;
	logic [3:0]  sel = 4'hF;
	logic [7:0]  xc;
	logic [17:0] rows [3] = '{18'h3_00C0, 18'h2_0080, 18'h0_E73F};
	always #2 clk_i = ~clk_i;
	// Edges since reset release, to predict the running down-counter
	always @(posedge clk_i) t <= rst_i ? 0 : t + 1;
	pwmcps_top DUT (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req[50]),
		.wb_stb_i(req[49]), .wb_we_i(req[48]), .wb_adr_i(req[47:32]),
		.wb_sel_i(sel), .wb_dat_i(req[31:0]), .wb_dat_o(dr),
		.wb_ack_o(ack), .wb_err_o(err), .port_six_bit_six_o(p6),
		.port_six_bit_seven_o(p7), .wave_fields_o(wf), .wave_ctrl_o(wc));
	task chk(input [31:0] g, input [31:0] x);
		n_compared++;
		if (g !== x) begin
			num_errors++;
			$display("wrong value at %0t: %h, expected %h", $time, g, x);
		end
	endtask
	task bus(input w, input [15:0] a, input [31:0] d);
		@(posedge clk_i);
		req <= {2'b11, w, a, d};
		do @(posedge clk_i); while (!ack && !err);
		r = dr;
		e = err;
		tk = t;
		req[50:49] <= 2'b00;
	endtask
	task meas(input int n);
		repeat (1100) @(negedge clk_i);
		h6 = 0;
		h7 = 0;
		repeat (n) begin
			@(negedge clk_i);
			h6 += p6;
			h7 += p7;
		end
	endtask
	task stop_test;
		$display("errors %0d, compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		// Tests take about 6000 cycles; this leaves ample margin
		#60000;
		num_errors++;
		stop_test;
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		bus(0, `PWMCPS_ADDR_PIN_CFG, 0);
		chk(r, 0);
		for (i = 0; i < 3; i++) begin
			v = rows[i];
			bus(1, `PWMCPS_ADDR_PIN_CFG, v[15:0]);
			repeat (2) @(negedge clk_i);
			chk({p7, p6}, v[17:16]);
			chk({wc, wf}, {2'b0, v[15:13], v[10:8], v[5:0]});
			bus(0, `PWMCPS_ADDR_PIN_CFG, 0);
			chk(r, v[15:0]);
		end
		bus(0, 16'h1FA0, 0);
		chk(e, 1);
		bus(1, `PWMCPS_ADDR_DUTY0, 8'hFF);
		bus(1, `PWMCPS_ADDR_DUTY1, 0);
		bus(1, `PWMCPS_ADDR_PIN_CFG, 16'h1800);
		bus(1, `PWMCPS_ADDR_COUNT, 8'h55);
		bus(0, `PWMCPS_ADDR_COUNT, 0);
		// Period 0: one downward step every state time since reset
		xc = 8'hFF - (tk - 3) / 2;
		chk(r, xc);
		// Wait past one full period so the buffered duties are in use
		meas(512);
		chk(h6, 510);
		chk(h7, 0);
		bus(1, `PWMCPS_ADDR_PERIOD, 1);
		meas(1024);
		chk(h6, 1020);
		// At least 16 counter steps before the period end, so the new duty must not show yet
		do bus(0, `PWMCPS_ADDR_COUNT, 0); while (r[7:0] < 8'h10);
		bus(1, `PWMCPS_ADDR_DUTY0, 0);
		repeat (4) @(negedge clk_i);
		chk(p6, 1);
		meas(1024);
		chk(h6, 0);
		@(posedge clk_i);
		sel <= 4'h2;
		bus(1, `PWMCPS_ADDR_PIN_CFG, 32'h10FF);
		bus(0, `PWMCPS_ADDR_PIN_CFG, 0);
		chk(r, 32'h1000);
		sel <= 4'hF;
		rst_i <= 1;
		@(posedge clk_i);
		rst_i <= 0;
		bus(0, `PWMCPS_ADDR_PIN_CFG, 0);
		chk(r, 0);
		chk({p7, p6}, 0);
		stop_test;
	end
endmodule
bind pwmcps_top pwmcps_asserts u_chk (.*);
